// file: rtl/rrcs_buffer_end.sv
// Buffering end: per-channel occupancy, status broadcast, request acceptance.
// Assumes the scheduler shares clock_in and rst_n_in; user push/pop same clock.
`timescale 1ns/10ps
`default_nettype none
`include "rrcs_regs.svh"

module rrcs_buffer_end
  import rrcs_pkg::*;
#(
  parameter  int NUM_CH   = 2,
  parameter  int LVL_W    = 4,
  parameter  int AF_LEVEL = 12,
  localparam int IDX_W    = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
  localparam int ADDR_W   = IDX_W + `RRCS_ADDR_SHIFT
)
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  rrcs_if.buffer           req,
  input  wire logic        push_valid_in,
  input  wire rrcs_ch_t    push_ch_in,
  input  wire logic        pop_ready_in,
  output logic             pop_valid_out,
  output logic [IDX_W-1:0] pop_ch_out
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (NUM_CH < `RRCS_MIN_CH || NUM_CH > `RRCS_MAX_CH)
  begin : g_bad_num_ch
    $error("rrcs_buffer_end: NUM_CH outside 2..32");
  end
  if (AF_LEVEL < 1 || AF_LEVEL >= (1 << LVL_W))
  begin : g_bad_af
    $error("rrcs_buffer_end: AF_LEVEL not representable in LVL_W");
  end

  localparam logic [IDX_W-1:0] LAST_CH = IDX_W'(NUM_CH - 1);
  localparam logic [LVL_W-1:0] AF_LVL  = LVL_W'(AF_LEVEL);
  localparam logic [LVL_W-1:0] LVL_MAX = '1;
  localparam logic [`RRCS_CH_W:0] CH_LIMIT = (`RRCS_CH_W+1)'(NUM_CH);

  // ****************************************************************
  // Request acceptance
  // ****************************************************************
  logic [LVL_W-1:0] level_q [NUM_CH];
  logic             wait_q;
  logic             popv_q;
  logic [IDX_W-1:0] popch_q;
  logic [IDX_W-1:0] st_ptr_q;
  logic             afv_q;
  rrcs_ch_t         afch_q;
  logic             afd_q;

  wire             accept  = req.req_write && !wait_q;
  wire [IDX_W-1:0] req_ch  = req.req_address[ADDR_W-1:`RRCS_ADDR_SHIFT];
  wire             push_ok = push_valid_in && ({1'b0, push_ch_in} < CH_LIMIT);
  wire [IDX_W-1:0] st_next = (st_ptr_q == LAST_CH) ? '0 : st_ptr_q + 1'b1;

  // Waitrequest is registered, so a drop of pop_ready shows a cycle late.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wait_q  <= 1'b1;
      popv_q  <= 1'b0;
      popch_q <= '0;
    end
    else
    begin
      wait_q  <= !pop_ready_in;                                    // [RULE7]
      popv_q  <= accept;
      popch_q <= req_ch;
    end
  end

  // ****************************************************************
  // Per-channel occupancy
  // ****************************************************************
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_lvl
    wire inc = push_ok && (push_ch_in == rrcs_ch_t'(i)) && (level_q[i] != LVL_MAX);
    wire dec = accept && (req_ch == IDX_W'(i)) && (level_q[i] != '0);

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        level_q[i] <= '0;
      end
      else if (inc && !dec)
      begin
        level_q[i] <= level_q[i] + 1'b1;
      end
      else if (dec && !inc)
      begin
        level_q[i] <= level_q[i] - 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status broadcast, one channel per cycle
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_ptr_q <= '0;
      afv_q    <= 1'b0;
      afch_q   <= '0;
      afd_q    <= 1'b0;
    end
    else
    begin
      st_ptr_q <= st_next;
      afv_q    <= 1'b1;                                            // [RULE10]
      afch_q   <= rrcs_ch_t'(st_ptr_q);                            // [RULE9]
      afd_q    <= level_q[st_ptr_q] >= AF_LVL;                     // [RULE11]
    end
  end

  assign req.req_waitrequest = wait_q;
  assign req.af_valid        = afv_q;
  assign req.af_channel      = afch_q;
  assign req.af_data         = afd_q;
  assign pop_valid_out       = popv_q;
  assign pop_ch_out          = popch_q;

endmodule : rrcs_buffer_end

`default_nettype wire

// file: rtl/rrcs_if.sv
// Link between the round-robin scheduler and the channel buffering end.
// Assumes both ends share one clock and one reset.
`timescale 1ns/10ps
`default_nettype none
`include "rrcs_regs.svh"

interface rrcs_if
  import rrcs_pkg::*;
#(
  parameter int ADDR_W = 3
);
  logic [ADDR_W-1:0] req_address;
  logic              req_write;
  rrcs_data_t        req_writedata;
  logic              req_waitrequest;
  logic              af_valid;
  rrcs_ch_t          af_channel;
  logic              af_data;

  modport sched (
    output req_address,
    output req_write,
    output req_writedata,
    input  req_waitrequest,
    input  af_valid,
    input  af_channel,
    input  af_data
  );

  modport buffer (
    input  req_address,
    input  req_write,
    input  req_writedata,
    output req_waitrequest,
    output af_valid,
    output af_channel,
    output af_data
  );
endinterface : rrcs_if

`default_nettype wire

// file: rtl/rrcs_pkg.sv
// Types shared by the scheduler, the buffering end and their interface.
// Assumes rrcs_regs.svh is on the include path.
`include "rrcs_regs.svh"

package rrcs_pkg;
  typedef logic [`RRCS_CH_W-1:0]   rrcs_ch_t;
  typedef logic [`RRCS_REQ_DW-1:0] rrcs_data_t;
endpackage : rrcs_pkg

// file: rtl/rrcs_regs.svh
// Timing-free constants shared by both ends of the channel read scheduler link.
// Assumes inclusion by bare name from files compiled under rtl/.
`ifndef RRCS_REGS_SVH
`define RRCS_REGS_SVH

// ****************************************************************
// Request side
// ****************************************************************
`define RRCS_ADDR_SHIFT 2
`define RRCS_REQ_DW     32
`define RRCS_REQ_ONE    32'h0000_0001

// ****************************************************************
// Status side and channel range
// ****************************************************************
`define RRCS_CH_W       5
`define RRCS_MIN_CH     2
`define RRCS_MAX_CH     32

`endif

// file: rtl/rrcs_scheduler.sv
// Round-robin scheduler issuing one-unit read requests to a channel buffer.
// Assumes the buffer end drives waitrequest and status on this same clock.
//
// How it works
// [RULE1] Never request a channel last reported almost full; a request held under waitrequest stays up if its channel turns almost full
// [RULE2] Request write data is always one
// [RULE3] Channel n is requested at address 4n
// [RULE4] Move to next channel every cycle, ascending
// [RULE5] Almost-full turn: idle cycle, then move on
// [RULE6] Hold and pause while waitrequest is high
// [RULE7] Buffer raises waitrequest when it cannot accept
// [RULE8] Asynchronous active-low reset, single clock
// [RULE9] Five-bit status channel, recorded per channel
// [RULE10] One-bit status, no backpressure, taken when valid
// [RULE11] Status fields count only while valid high
// [RULE12] Channel count parameter 2 to 32, default 2
// [RULE13] Option to use status, off by default
// [RULE14] Write-only master, no reads, no bursts
// [RULE15] Wrap after last channel; reset to channel zero
// [RULE16] Request held stable until accepted
`timescale 1ns/10ps
`default_nettype none
`include "rrcs_regs.svh"

module rrcs_scheduler
  import rrcs_pkg::*;
#(
  parameter  int NUM_CH = 2,
  parameter  bit USE_AF = 1'b0,
  localparam int IDX_W  = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
  localparam int ADDR_W = IDX_W + `RRCS_ADDR_SHIFT
)
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  rrcs_if.sched            req,
  output logic             stall_out,
  output logic             skip_out,
  output logic [IDX_W-1:0] turn_out
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // [RULE12] counts outside the legal channel range refused at build time
  if (NUM_CH < `RRCS_MIN_CH || NUM_CH > `RRCS_MAX_CH)
  begin : g_bad_num_ch
    $error("rrcs_scheduler: NUM_CH outside 2..32");
  end

  if (ADDR_W != $bits(req.req_address))
  begin : g_bad_addr_w
    $error("rrcs_scheduler: interface address width mismatch");
  end

  if (IDX_W > `RRCS_CH_W)
  begin : g_bad_idx_w
    $error("rrcs_scheduler: channel index wider than status field");
  end

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam logic [IDX_W-1:0] LAST_CH = IDX_W'(NUM_CH - 1);
  localparam logic [`RRCS_ADDR_SHIFT-1:0] ADDR_PAD = '0;
  // One bit wider than the channel field, so a count of 32 stays nonzero
  localparam logic [`RRCS_CH_W:0]         CH_LIMIT = (`RRCS_CH_W+1)'(NUM_CH);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [IDX_W-1:0]  ptr_q;
  logic [IDX_W-1:0]  ptr_d;
  logic              write_q;
  logic              write_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  rrcs_data_t        wdata_q;
  logic [NUM_CH-1:0] af_q;
  logic              skip_q;
  logic              stall_q;
  logic [NUM_CH-1:0] af_upd;

  // ****************************************************************
  // Status sink decode
  // ****************************************************************
  // No ready exists on the status sink, so every valid beat is taken.
  wire       st_take  = USE_AF && req.af_valid;                    // [RULE10] [RULE13]
  // Reports for channels beyond NUM_CH must not alias onto a low channel.
  wire       st_range = {1'b0, req.af_channel} < CH_LIMIT;          // [RULE9]
  wire       st_hit   = st_take && (req.af_channel == rrcs_ch_t'(ptr_q)); // [RULE11]

  // Bypass so a report landing this very cycle counts as most recent.
  wire       af_now   = st_hit ? req.af_data : af_q[ptr_q];        // [RULE1]
  wire       skip_now = USE_AF && af_now;                          // [RULE5] [RULE13]

  // ****************************************************************
  // Request path
  // ****************************************************************
  // A request is outstanding only while write is high and refused.
  wire       stalled  = write_q && req.req_waitrequest;            // [RULE6] [RULE7]
  // Everything that moves with the turn advances only on this.
  wire       load     = !stalled;                                  // [RULE6]
  // A held request is not withdrawn if its channel turns almost full while
  // waiting; holding it is what the request bus demands of a master.
  wire       ptr_wrap = (ptr_q == LAST_CH);                        // [RULE15]

  assign ptr_d   = ptr_wrap ? '0 : ptr_q + 1'b1;                   // [RULE4] [RULE15]
  assign write_d = !skip_now;                                      // [RULE1] [RULE5]
  assign addr_d  = {ptr_q, ADDR_PAD};                              // [RULE3]

  // ****************************************************************
  // Round-robin pointer and request registers
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_n_in)                // [RULE8]
  begin
    if (!rst_n_in)
    begin
      ptr_q <= '0;                                                 // [RULE15]
    end
    else if (load)                                                 // [RULE6]
    begin
      ptr_q <= ptr_d;                                              // [RULE4]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      write_q <= 1'b0;
      addr_q  <= '0;
    end
    else if (load)                                                 // [RULE16]
    begin
      write_q <= write_d;                                          // [RULE14]
      addr_q  <= addr_d;                                           // [RULE3]
    end
  end

  // Data is a constant, but kept in a flop so every output is registered.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wdata_q <= `RRCS_REQ_ONE;                                    // [RULE2]
    end
    else
    begin
      wdata_q <= `RRCS_REQ_ONE;                                    // [RULE2]
    end
  end

  // ****************************************************************
  // Almost-full record, one flag per channel
  // ****************************************************************
  // Reports for channels beyond NUM_CH are dropped, not aliased.
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_af
    assign af_upd[i] = st_take && st_range
                       && (req.af_channel == rrcs_ch_t'(i));       // [RULE9] [RULE11]

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
      if (!rst_n_in)
      begin
        af_q[i] <= 1'b0;                                           // [RULE15]
      end
      else if (af_upd[i])
      begin
        af_q[i] <= req.af_data;                                    // [RULE11]
      end
    end
  end

  // ****************************************************************
  // Observation outputs
  // ****************************************************************
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      skip_q <= 1'b0;
    end
    else
    begin
      skip_q <= load && skip_now;                                  // [RULE5]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stall_q <= 1'b0;
    end
    else
    begin
      stall_q <= stalled;                                          // [RULE6]
    end
  end

  // ****************************************************************
  // Port drive
  // ****************************************************************
  assign req.req_address   = addr_q;                               // [RULE16]
  assign req.req_write     = write_q;                              // [RULE14]
  assign req.req_writedata = wdata_q;                              // [RULE2]
  assign stall_out         = stall_q;
  assign skip_out          = skip_q;
  assign turn_out          = ptr_q;

endmodule : rrcs_scheduler

`default_nettype wire

// file: tb/round_robin_channel_read_scheduler_tb.sv
// Bench joining the scheduler to the buffering end, checker alongside.
// Assumes the rtl files and tb/rrcs_chk.sv are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module round_robin_channel_read_scheduler_tb
  import rrcs_pkg::*;
();
  localparam int NCH = 4;

  logic       clock_in;
  logic       rst_n_in;
  logic       push_valid_in;
  rrcs_ch_t   push_ch_in;
  logic       pop_ready_in;
  logic       pop_valid_out;
  logic [1:0] pop_ch_out;
  logic       stall_seen;
  logic       skip_seen;
  logic [1:0] turn_seen;
  logic       pop2_valid;
  logic [1:0] pop2_ch;
  logic       skip2_seen;
  int         skips = 0;
  int         stalls = 0;
  int         exp2_q[$];
  int         fails = 0;
  int         tests_run = 0;
  int         seed = 11;
  int         skip_ch = -1;
  int         exp_q[$];

  rrcs_if #(.ADDR_W(4)) link ();

  rrcs_scheduler #(.NUM_CH(NCH), .USE_AF(1'b1)) i_rrcs_scheduler (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req(link.sched),
    .stall_out(stall_seen), .skip_out(skip_seen), .turn_out(turn_seen));

  rrcs_buffer_end #(.NUM_CH(NCH)) i_rrcs_buffer_end (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req(link.buffer),
    .push_valid_in(push_valid_in), .push_ch_in(push_ch_in), .pop_ready_in(pop_ready_in),
    .pop_valid_out(pop_valid_out), .pop_ch_out(pop_ch_out));

  // Same traffic into a pair with the status option left off
  rrcs_if #(.ADDR_W(4)) link_plain ();

  rrcs_scheduler #(.NUM_CH(NCH)) i_rrcs_scheduler_plain (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req(link_plain.sched),
    .stall_out(), .skip_out(skip2_seen), .turn_out());

  rrcs_buffer_end #(.NUM_CH(NCH)) i_rrcs_buffer_end_plain (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req(link_plain.buffer),
    .push_valid_in(push_valid_in), .push_ch_in(push_ch_in), .pop_ready_in(pop_ready_in),
    .pop_valid_out(pop2_valid), .pop_ch_out(pop2_ch));

  rrcs_chk #(.NUM_CH(NCH), .ADDR_W(4)) i_rrcs_chk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .req_address(link.req_address),
    .req_write(link.req_write), .req_writedata(link.req_writedata),
    .req_waitrequest(link.req_waitrequest), .af_valid(link.af_valid),
    .af_channel(link.af_channel), .af_data(link.af_data));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv)
    begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, expv, seen);
    end
  endtask : check

  // Stalls never break the order, so the whole pop order is known up front
  task automatic plan(input int n);
    for (int i = 0; i < n; i++)
    begin
      exp2_q.push_back(i % NCH);
      if (i % NCH != skip_ch)
        exp_q.push_back(i % NCH);
    end
  endtask : plan

  function automatic int pull(ref int q[$]);
    return q.size() ? q.pop_front() : 99;
  endfunction : pull

  task automatic do_reset();
    rst_n_in <= 1'b0;
    exp_q.delete();
    exp2_q.delete();
    skips  = 0;
    stalls = 0;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
  endtask : do_reset

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  initial
  begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // Pops land after the edge, so compare on the falling edge
  always @(negedge clock_in)
    if (rst_n_in === 1'b1)
    begin
      if (pop_valid_out === 1'b1)
        check("pop_ch", pop_ch_out, pull(exp_q));
      if (pop2_valid === 1'b1)
        check("plain_pop_ch", pop2_ch, pull(exp2_q));
      check("plain_skip", skip2_seen, 1'b0);
      if (skip_seen === 1'b1)
        check("skip_turn", turn_seen, (skip_ch + 1) % NCH);
      if (stall_seen === 1'b1)
        check("stall_no_pop", pop_valid_out, 1'b0);
      skips  += (skip_seen === 1'b1);
      stalls += (stall_seen === 1'b1);
    end

  initial
  begin
    #(2000 * 100);
    fails++;
    finish_test();
  end

  initial
  begin
    rst_n_in      = 1'b0;
    push_valid_in = 1'b0;
    push_ch_in    = 5'h00;
    pop_ready_in  = 1'b1;
    do_reset();
    plan(400);
    // Random stalls; pushes mostly aimed at channels out of range
    repeat (200)
    begin
      @(posedge clock_in);
      pop_ready_in  <= ($random(seed) & 32'h3) != 0;
      push_valid_in <= ($random(seed) & 32'h7) == 0;
      push_ch_in    <= rrcs_ch_t'($random(seed));
    end
    @(posedge clock_in);
    push_valid_in <= 1'b0;
    pop_ready_in  <= 1'b0;
    check("no_skips", skips, 0);
    // Second reset, then one channel filled past the almost-full mark
    do_reset();
    skip_ch = 1 + ($random(seed) & 32'h3) % 3;
    push_ch_in    <= rrcs_ch_t'(skip_ch);
    push_valid_in <= 1'b1;
    repeat (16) @(posedge clock_in);
    push_valid_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    plan(200);
    pop_ready_in <= 1'b1;
    repeat (100) @(posedge clock_in);
    check("pops_done", exp_q.size() < 100, 1'b1);
    check("plain_pops_done", exp2_q.size() < 150, 1'b1);
    check("skips_seen", skips > 0, 1'b1);
    check("stalls_seen", stalls > 0, 1'b1);
    finish_test();
  end
endmodule : round_robin_channel_read_scheduler_tb

`default_nettype wire

// file: tb/rrcs_chk.sv
// Checker for the scheduler link: request and status signals.
// Assumes one clock; the bench wires the interface signals in by name.
`timescale 1ns/10ps
`default_nettype none
`include "rrcs_regs.svh"

module rrcs_chk
  import rrcs_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int ADDR_W = 3
)
(
  input wire logic              clock_in,
  input wire logic              rst_n_in,
  input wire logic [ADDR_W-1:0] req_address,
  input wire logic              req_write,
  input wire rrcs_data_t        req_writedata,
  input wire logic              req_waitrequest,
  input wire logic              af_valid,
  input wire rrcs_ch_t          af_channel,
  input wire logic              af_data
);
  logic        first_q;
  logic [31:0] af_q;
  logic [31:0] af_d;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  // Status of this cycle counts too, as the scheduler bypasses it
  always_comb
  begin
    af_d = af_q;
    if (af_valid && int'(af_channel) < NUM_CH)
      af_d[af_channel] = af_data;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) af_q <= 32'h0000_0000;
    else af_q <= af_d;

  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) first_q <= 1'b1;
    else first_q <= 1'b0;

  AST_DATA_ONE: assert property (req_write |-> req_writedata == `RRCS_REQ_ONE)
    else $error("request data is not one");
  AST_ADDR_OK: assert property (req_write |-> req_address[1:0] == 2'h0
    && int'(req_address[ADDR_W-1:2]) < NUM_CH) else $error("request address off the map");
  AST_HOLD: assert property (req_write && req_waitrequest |=>
    req_write && $stable(req_address) && $stable(req_writedata))
    else $error("request changed while waiting");
  AST_STEP: assert property (req_write && !req_waitrequest |=> !req_write
    || req_address == ADDR_W'((($past(req_address) / 4 + 1) % NUM_CH) * 4))
    else $error("next request is not the following channel");
  AST_SKIP_AF: assert property (!(req_write && req_waitrequest) ##1 req_write
    |-> !af_q[req_address[ADDR_W-1:2]]) else $error("request to almost-full channel");
  AST_FIRST: assert property (first_q && rst_n_in |=>
    req_write && req_address == '0)
    else $error("first request after reset is not channel zero");
  AST_AF_STEP: assert property (af_valid |=> af_valid
    && af_channel == rrcs_ch_t'(($past(af_channel) + 1) % NUM_CH))
    else $error("status channel out of turn");
  AST_AF_RANGE: assert property (af_valid |-> int'(af_channel) < NUM_CH)
    else $error("status channel beyond channel count");

  cover property (req_write && !req_waitrequest);
  cover property (req_write && req_waitrequest [*2]);
  cover property (req_write && !req_waitrequest ##1 !req_write);
  cover property (af_valid && af_data);
endmodule : rrcs_chk

`default_nettype wire
